// >>> pdl_pkg.sv
// constants and field layout of the device control, device status and link capability registers
package pdl_pkg;

  // configuration offsets
  localparam logic [7:0] DEV_CTL_OFFSET = 8'h78;
  localparam logic [7:0] DEV_STS_OFFSET = 8'h7a;
  localparam logic [7:0] LINK_CAP_OFFSET = 8'h7c;

  // device control layout
  localparam logic [15:0] DEV_CTL_RESET = 16'h2810;
  localparam logic [15:0] DEV_CTL_RW_MASK = 16'h7dff;
  localparam logic [15:0] DEV_CTL_AUX_MASK = 16'h0400;
  localparam int FLR_BIT = 15;
  localparam int READ_REQ_LSB = 12;
  localparam int SNOOP_SKIP_BIT = 11;
  localparam int AUX_PM_BIT = 10;
  localparam int PHANTOM_BIT = 9;
  localparam int EXT_TAG_BIT = 8;
  localparam int PAYLOAD_LSB = 5;
  localparam int RELAX_ORD_BIT = 4;
  localparam int REPORT_LSB = 0;

  // read request size decode
  localparam logic [12:0] READ_REQ_BASE_BYTES = 13'h0080;
  localparam logic [12:0] READ_REQ_TOP_BYTES = 13'h1000;
  localparam logic [12:0] READ_REQ_RESET_BYTES = 13'h0200;
  localparam logic [2:0] READ_REQ_MAX_CODE = 3'h5;

  // device status layout
  localparam logic [9:0] STS_RSVD_VALUE = 10'h000;
  localparam int STS_CLR_LSB = 16;

  // link capability fields
  localparam logic [7:0] LCAP_PORT_NUM = 8'h00;
  localparam logic [4:0] LCAP_RSVD = 5'h00;
  localparam logic LCAP_CLOCK_PM = 1'b1;
  localparam logic [1:0] LCAP_ASPM = 2'h3;
  localparam logic [5:0] LCAP_LANES = 6'h01;
  localparam logic [3:0] LCAP_RATE = 4'h2;

endpackage

// >>> pdl_regs.sv
// device control, device status and link capability register logic
`timescale 1ns/1ps
module pdl_regs
(
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic func_rst_i,
  // configuration access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // hardware events and state
  input wire logic [3:0] err_detect_i,
  input wire logic transaction_outstanding_i,
  input wire logic aux_power_sense_pin_i,
  // exit latency settings and link control
  input wire logic [2:0] l1_exit_setting_async_i,
  input wire logic [2:0] l1_exit_setting_shared_clock_i,
  input wire logic [2:0] l0s_exit_setting_async_i,
  input wire logic [2:0] l0s_exit_setting_shared_clock_i,
  input wire logic common_clock_cfg_i,
  // upstream request header
  input wire logic req_vc_nonzero_i,
  output logic req_no_snoop_o,
  // control outputs
  output logic function_reset_o,
  output logic [2:0] read_request_size_limit_o,
  output logic [12:0] read_request_max_bytes_o,
  output logic [2:0] payload_size_limit_o,
  output logic extended_tag_enable_o,
  output logic relaxed_ordering_enable_o,
  output logic [3:0] report_enable_o,
  output logic snoop_skip_enable_o,
  output logic aux_power_mgmt_enable_o,
  // status outputs
  output logic [3:0] error_seen_o,
  output logic aux_power_present_o
);

  typedef struct packed {
    logic [15:0] ctl;
    logic [3:0] err;
    logic aux_meta;
    logic aux_sync;
    logic [31:0] rdata;
    logic rvalid;
    logic flr;
    logic no_snoop;
    logic [12:0] max_bytes;
  } pdl_state_t;

  pdl_state_t state_reg;
  pdl_state_t state_next;

  logic hit_ctl;
  logic hit_cap;
  logic [15:0] wr_mask;
  logic [15:0] wr_ctl;
  logic [3:0] err_clr;
  logic flr_req;
  logic [2:0] l1_sel;
  logic [2:0] l0s_sel;
  logic [15:0] ctl_view;
  logic [15:0] sts_view;
  logic [31:0] cap_view;

  always_comb
  begin
    hit_ctl = (cfg_addr_i[7:2] == pdl_pkg::DEV_CTL_OFFSET[7:2]);
    hit_cap = (cfg_addr_i[7:2] == pdl_pkg::LINK_CAP_OFFSET[7:2]);
    // exit latency source follows the common clock bit
    l1_sel = common_clock_cfg_i ? l1_exit_setting_shared_clock_i
                                : l1_exit_setting_async_i;
    l0s_sel = common_clock_cfg_i ? l0s_exit_setting_shared_clock_i
                                 : l0s_exit_setting_async_i;
    cap_view = {pdl_pkg::LCAP_PORT_NUM,
                pdl_pkg::LCAP_RSVD,
                pdl_pkg::LCAP_CLOCK_PM,
                l1_sel, l0s_sel,
                pdl_pkg::LCAP_ASPM,
                pdl_pkg::LCAP_LANES,
                pdl_pkg::LCAP_RATE};
    // trigger and phantom bits are never stored
    ctl_view = state_reg.ctl & pdl_pkg::DEV_CTL_RW_MASK;
    sts_view = {pdl_pkg::STS_RSVD_VALUE,
                transaction_outstanding_i,
                state_reg.aux_sync,
                state_reg.err};
    wr_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}} & pdl_pkg::DEV_CTL_RW_MASK;
    wr_ctl = state_reg.ctl;
    err_clr = 4'h0;
    flr_req = 1'b0;
    if (cfg_wr_i && hit_ctl)
    begin
      wr_ctl = (state_reg.ctl & ~wr_mask) | (cfg_wdata_i[15:0] & wr_mask);
      flr_req = cfg_be_i[1] && cfg_wdata_i[pdl_pkg::FLR_BIT];
      if (cfg_be_i[2])
      begin
        err_clr = cfg_wdata_i[pdl_pkg::STS_CLR_LSB +: 4];
      end
    end
    flr_req = flr_req || func_rst_i;

    state_next = state_reg;
    state_next.aux_meta = aux_power_sense_pin_i;
    state_next.aux_sync = state_reg.aux_meta;
    state_next.ctl = wr_ctl;
    // hardware set wins over a clearing write
    state_next.err = (state_reg.err & ~err_clr) | err_detect_i;
    if (flr_req)
    begin
      state_next.ctl = (pdl_pkg::DEV_CTL_RESET & ~pdl_pkg::DEV_CTL_AUX_MASK)
                     | (wr_ctl & pdl_pkg::DEV_CTL_AUX_MASK);
      state_next.err = err_detect_i;
    end
    state_next.flr = flr_req;
    state_next.no_snoop = req_vc_nonzero_i && state_next.ctl[pdl_pkg::SNOOP_SKIP_BIT];
    if (state_next.ctl[pdl_pkg::READ_REQ_LSB +: 3] > pdl_pkg::READ_REQ_MAX_CODE)
    begin
      state_next.max_bytes = pdl_pkg::READ_REQ_TOP_BYTES;
    end
    else
    begin
      state_next.max_bytes = 13'(pdl_pkg::READ_REQ_BASE_BYTES
                                 << state_next.ctl[pdl_pkg::READ_REQ_LSB +: 3]);
    end
    state_next.rvalid = cfg_rd_i;
    if (cfg_rd_i)
    begin
      if (hit_ctl)
      begin
        state_next.rdata = {sts_view, ctl_view};
      end
      else if (hit_cap)
      begin
        state_next.rdata = cap_view;
      end
      else
      begin
        state_next.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg.ctl <= pdl_pkg::DEV_CTL_RESET;
      state_reg.err <= 4'h0;
      state_reg.aux_meta <= 1'b0;
      state_reg.aux_sync <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.rvalid <= 1'b0;
      state_reg.flr <= 1'b0;
      state_reg.no_snoop <= 1'b0;
      state_reg.max_bytes <= pdl_pkg::READ_REQ_RESET_BYTES;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign cfg_rdata_o = state_reg.rdata;
  assign cfg_rvalid_o = state_reg.rvalid;
  assign req_no_snoop_o = state_reg.no_snoop;
  assign function_reset_o = state_reg.flr;
  assign read_request_size_limit_o = state_reg.ctl[pdl_pkg::READ_REQ_LSB +: 3];
  assign read_request_max_bytes_o = state_reg.max_bytes;
  assign payload_size_limit_o = state_reg.ctl[pdl_pkg::PAYLOAD_LSB +: 3];
  assign extended_tag_enable_o = state_reg.ctl[pdl_pkg::EXT_TAG_BIT];
  assign relaxed_ordering_enable_o = state_reg.ctl[pdl_pkg::RELAX_ORD_BIT];
  assign report_enable_o = state_reg.ctl[pdl_pkg::REPORT_LSB +: 4];
  assign snoop_skip_enable_o = state_reg.ctl[pdl_pkg::SNOOP_SKIP_BIT];
  assign aux_power_mgmt_enable_o = state_reg.ctl[pdl_pkg::AUX_PM_BIT];
  assign error_seen_o = state_reg.err;
  assign aux_power_present_o = state_reg.aux_sync;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  flr_trigger_pulse_a: assert property (
    cfg_wr_i && hit_ctl && cfg_be_i[1] && cfg_wdata_i[15]
    |=> function_reset_o && read_request_size_limit_o == 3'h2 && snoop_skip_enable_o)
    else $error("function reset trigger did not restore control");

  flr_reads_zero_a: assert property (
    cfg_rd_i && hit_ctl |=> !cfg_rdata_o[15] && !cfg_rdata_o[9])
    else $error("trigger or phantom bit read as one");

  read_cap_bytes_a: assert property (
    read_request_size_limit_o == 3'h3 |-> read_request_max_bytes_o == 13'h0400)
    else $error("read request cap does not match its code");

  snoop_copy_a: assert property (
    req_vc_nonzero_i && !cfg_wr_i && !func_rst_i
    |=> req_no_snoop_o == $past(snoop_skip_enable_o))
    else $error("no-snoop flag not copied from control");

  aux_enable_kept_a: assert property (
    !cfg_wr_i ##1 function_reset_o |-> $stable(aux_power_mgmt_enable_o))
    else $error("auxiliary enable changed on function reset");

  status_reserved_a: assert property (
    cfg_rd_i && hit_ctl |=> cfg_rdata_o[31:22] == 10'h000)
    else $error("status reserved bits not zero");

  aux_mirror_a: assert property (
    aux_power_sense_pin_i [*3] |=> aux_power_present_o)
    else $error("aux power flag does not follow the pin");

  err_set_wins_a: assert property (
    err_detect_i[2] |=> error_seen_o[2])
    else $error("fatal error event lost");

  err_clear_a: assert property (
    cfg_wr_i && hit_ctl && cfg_be_i[2] && cfg_wdata_i[16] && !err_detect_i[0]
    |=> !error_seen_o[0])
    else $error("correctable flag not cleared by write of one");

  link_cap_const_a: assert property (
    cfg_rd_i && hit_cap
    |=> cfg_rdata_o[31:18] == 14'h0001 && cfg_rdata_o[11:0] == 12'hc12)
    else $error("link capability constant fields wrong");

  latency_select_a: assert property (
    cfg_rd_i && hit_cap && common_clock_cfg_i
    |=> cfg_rdata_o[17:15] == $past(l1_exit_setting_shared_clock_i)
        && cfg_rdata_o[14:12] == $past(l0s_exit_setting_shared_clock_i))
    else $error("exit latency not taken from shared clock setting");

  latency_async_a: assert property (
    cfg_rd_i && hit_cap && !common_clock_cfg_i
    |=> cfg_rdata_o[17:15] == $past(l1_exit_setting_async_i)
        && cfg_rdata_o[14:12] == $past(l0s_exit_setting_async_i))
    else $error("exit latency not taken from asynchronous setting");

  read_answer_a: assert property (
    cfg_rd_i
    |=> cfg_rvalid_o)
    else $error("read answer missing");

  read_quiet_a: assert property (
    !cfg_rd_i
    |=> !cfg_rvalid_o)
    else $error("read answer without a read");

  flr_quiet_a: assert property (
    !func_rst_i && !(cfg_wr_i && hit_ctl && cfg_be_i[1] && cfg_wdata_i[15])
    |=> !function_reset_o)
    else $error("function reset pulse without a trigger");

  func_rst_restore_a: assert property (
    func_rst_i
    |=> function_reset_o && read_request_size_limit_o == 3'h2 && payload_size_limit_o == 3'h0)
    else $error("function reset did not restore control fields");

  func_rst_aux_a: assert property (
    func_rst_i && !cfg_wr_i
    |=> aux_power_mgmt_enable_o == $past(aux_power_mgmt_enable_o))
    else $error("auxiliary enable lost on function reset");

  func_rst_flags_a: assert property (
    func_rst_i && err_detect_i == 4'h0
    |=> error_seen_o == 4'h0)
    else $error("error flags kept over function reset");

  func_rst_enables_a: assert property (
    func_rst_i
    |=> report_enable_o == 4'h0 && !extended_tag_enable_o && relaxed_ordering_enable_o)
    else $error("enables not restored by function reset");

  ctl_low_store_a: assert property (
    cfg_wr_i && hit_ctl && cfg_be_i[0] && cfg_wdata_i[7:0] == 8'hff && !func_rst_i
    && !(cfg_be_i[1] && cfg_wdata_i[15]) |=> report_enable_o == 4'hf && payload_size_limit_o == 3'h7)
    else $error("low control byte not stored");

  ctl_lane_guard_a: assert property (
    cfg_wr_i && hit_ctl && !cfg_be_i[0] && !cfg_be_i[1] && !func_rst_i
    |=> $stable(report_enable_o) && $stable(read_request_size_limit_o))
    else $error("control changed without its byte enables");

  cap_write_ignored_a: assert property (
    cfg_wr_i && !hit_ctl && !func_rst_i
    |=> $stable(read_request_size_limit_o) && $stable(snoop_skip_enable_o))
    else $error("write outside control changed control");

  unmapped_zero_a: assert property (
    cfg_rd_i && !hit_ctl && !hit_cap
    |=> cfg_rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  read_cap_sat_a: assert property (
    read_request_size_limit_o > 3'h5
    |-> read_request_max_bytes_o == 13'h1000)
    else $error("reserved read request code not capped");

  read_cap_base_a: assert property (
    read_request_size_limit_o == 3'h0
    |-> read_request_max_bytes_o == 13'h0080)
    else $error("smallest read request cap wrong");

  read_cap_top_a: assert property (
    read_request_size_limit_o == 3'h5
    |-> read_request_max_bytes_o == 13'h1000)
    else $error("largest read request cap wrong");

  snoop_vc0_a: assert property (
    !req_vc_nonzero_i
    |=> !req_no_snoop_o)
    else $error("no-snoop flag set for VC0 request");

  aux_mirror_low_a: assert property (
    !aux_power_sense_pin_i [*3]
    |=> !aux_power_present_o)
    else $error("aux power flag high with pin low");

  err_sticky_a: assert property (
    error_seen_o[3] && !(cfg_wr_i && hit_ctl && cfg_be_i[2] && cfg_wdata_i[19]) && !func_rst_i
    |=> error_seen_o[3])
    else $error("error flag dropped without a clear");

  pending_live_a: assert property (
    cfg_rd_i && hit_ctl
    |=> cfg_rdata_o[21] == $past(transaction_outstanding_i))
    else $error("pending bit does not follow its input");

  aux_read_a: assert property (
    cfg_rd_i && hit_ctl
    |=> cfg_rdata_o[20] == $past(aux_power_present_o))
    else $error("aux power status bit read wrong");

endmodule // pdl_regs

// >>> pdl_root_model.sv
// root complex model issuing configuration reads and writes
`timescale 1ns/1ps
module pdl_root_model
(
  // clock
  input wire logic ref_clk_i,
  // configuration requests
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o,
  // read answer
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i
);
  initial
  begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0000_0000;
  end

  // one-cycle write, idle lines flipped afterwards
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk_i);
    #1;
    cfg_wr_o = 1'b1;
    cfg_addr_o = a;
    cfg_be_o = be;
    cfg_wdata_o = d;
    @(posedge ref_clk_i);
    #1;
    cfg_wr_o = 1'b0;
    cfg_addr_o = ~a;
    cfg_be_o = ~be;
    cfg_wdata_o = ~d;
  endtask

  // answer taken in the cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    #1;
    cfg_rd_o = 1'b1;
    cfg_addr_o = a;
    @(posedge ref_clk_i);
    #1;
    cfg_rd_o = 1'b0;
    cfg_addr_o = ~a;
    d = cfg_rvalid_i ? cfg_rdata_i : 32'hxxxx_xxxx;
  endtask
endmodule // pdl_root_model

// >>> pdl_regs_tb.sv
// self-checking bench for the configuration register block
`timescale 1ns/1ps
module pdl_regs_tb;
  logic ref_clk_i, rst_b_i, func_rst_i, cfg_rd, cfg_wr, cfg_rvalid, tx_out, aux_pin, ccc, vc_nz;
  logic no_snoop, frst, ext_tag, rlx, snoop_en, aux_en, aux_present;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, err_in, rpt_en, err_seen;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [2:0] rrs, payload_size_limit;
  logic [12:0] max_bytes;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  pdl_root_model u_pdl_root_model (.ref_clk_i(ref_clk_i), .cfg_rd_o(cfg_rd), .cfg_wr_o(cfg_wr),
    .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata),
    .cfg_rvalid_i(cfg_rvalid));

  pdl_regs u_pdl_regs (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .func_rst_i(func_rst_i),
    .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid),
    .err_detect_i(err_in), .transaction_outstanding_i(tx_out), .aux_power_sense_pin_i(aux_pin),
    .l1_exit_setting_async_i(3'h5), .l1_exit_setting_shared_clock_i(3'h2),
    .l0s_exit_setting_async_i(3'h3), .l0s_exit_setting_shared_clock_i(3'h6),
    .common_clock_cfg_i(ccc), .req_vc_nonzero_i(vc_nz), .req_no_snoop_o(no_snoop),
    .function_reset_o(frst), .read_request_size_limit_o(rrs), .read_request_max_bytes_o(max_bytes),
    .payload_size_limit_o(payload_size_limit), .extended_tag_enable_o(ext_tag),
    .relaxed_ordering_enable_o(rlx), .report_enable_o(rpt_en), .snoop_skip_enable_o(snoop_en),
    .aux_power_mgmt_enable_o(aux_en), .error_seen_o(err_seen), .aux_power_present_o(aux_present));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lcap(input logic [2:0] l1, input logic [2:0] l0);
    return {8'h00, 5'h00, 1'b1, l1, l0, 2'b11, 6'h01, 4'h2};
  endfunction

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      close_out();
    end
  end

  initial
  begin
    {rst_b_i, func_rst_i, tx_out, aux_pin, ccc, vc_nz, err_in} = '0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h0000_2810);
    u_pdl_root_model.rd(8'h7c, d);
    chk(d, lcap(3'h5, 3'h3));
    u_pdl_root_model.wr(8'h7c, 4'hf, 32'hffff_ffff);
    ccc = 1'b1;
    u_pdl_root_model.rd(8'h7c, d);
    chk(d, lcap(3'h2, 3'h6));
    u_pdl_root_model.wr(8'h78, 4'h3, 32'h0000_7fff);
    chk({31'h0, frst}, 32'h0);
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h0000_7dff);
    chk({18'h0, rrs, payload_size_limit, ext_tag, rlx, rpt_en, snoop_en, aux_en}, 32'h0000_3fff);
    for (int c = 0; c < 8; c++)
    begin
      u_pdl_root_model.wr(8'h78, 4'h3, {17'h0, c[2:0], 12'h0});
      chk({19'h0, max_bytes}, (c > 5) ? 32'h1000 : (32'h80 << c));
    end
    vc_nz = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk({31'h0, no_snoop}, 32'h0);
    u_pdl_root_model.wr(8'h78, 4'h3, 32'h0000_0800);
    @(posedge ref_clk_i);
    #1;
    chk({31'h0, no_snoop}, 32'h1);
    u_pdl_root_model.wr(8'h78, 4'h3, 32'h0000_8500);
    chk({31'h0, frst}, 32'h1);
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h0000_2c10);
    u_pdl_root_model.wr(8'h78, 4'h3, 32'h0000_04ff);
    func_rst_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    func_rst_i = 1'b0;
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h0000_2c10);
    rst_b_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h0000_2810);
    {err_in, tx_out, aux_pin} = {4'hf, 1'b1, 1'b1};
    @(posedge ref_clk_i);
    #1;
    err_in = 4'h0;
    repeat (3) @(posedge ref_clk_i);
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h003f_2810);
    u_pdl_root_model.wr(8'h78, 4'hc, 32'hffc1_0000);
    u_pdl_root_model.rd(8'h78, d);
    chk(d, 32'h003e_2810);
    chk({27'h0, aux_present, err_seen}, 32'h0000_001e);
    u_pdl_root_model.rd(8'h40, d);
    chk(d, 32'h0000_0000);
    close_out();
  end
endmodule // pdl_regs_tb
